/* hdl/rx_seq_pkg.sv */
// Register map, flag layout and widths of the channel driven by the receive sequencer
package rx_seq_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int TARGET_W = 7;
    localparam int LEN_W = 8;
    localparam int RETRY_W = 4;
    // Register indices of the channel
    localparam logic [ADDR_W-1:0] CHANNEL_CONTROL_REG = 2'h0;
    localparam logic [ADDR_W-1:0] CHANNEL_FLAG_REG = 2'h1;
    localparam logic [ADDR_W-1:0] TRANSMIT_DATA_REG = 2'h2;
    localparam logic [ADDR_W-1:0] RECEIVE_DATA_REG = 2'h3;
    // Control bit positions
    localparam int START_REQUEST_BIT = 0;
    localparam int STOP_REQUEST_BIT = 1;
    localparam int NACK_REQUEST_BIT = 2;
    // Flag bit positions, flags clear on writing 1
    localparam int TX_BUFFER_EMPTY_BIT = 0;
    localparam int RX_BUFFER_FULL_BIT = 1;
    localparam int START_SEEN_BIT = 2;
    localparam int STOP_SEEN_BIT = 3;
    localparam int NACK_RECEIVED_BIT = 4;
    localparam int TRANSFER_END_BIT = 5;
    localparam int DIRECTION_BIT = 6;
    // Address byte direction value
    localparam logic DIR_READ = 1'h1;
    localparam logic [LEN_W-1:0] LEN_ONE = 8'h01;
    localparam logic [LEN_W-1:0] LEN_TWO = 8'h02;
    localparam logic [LEN_W-1:0] LEN_ZERO = 8'h00;
    localparam logic [RETRY_W-1:0] RETRY_ZERO = 4'h0;
    localparam logic [RETRY_W-1:0] RETRY_ONE = 4'h1;
endpackage

/* hdl/reg_access.sv */
// Single register read or write towards the channel, one at a time
`timescale 1ns/100ps
module reg_access #(
    parameter int ADDR_W = rx_seq_pkg::ADDR_W,
    parameter int DATA_W = rx_seq_pkg::DATA_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Request from the sequencer
    input wire logic go,
    input wire logic is_read,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    // Channel register port
    output logic [ADDR_W-1:0] dev_addr,
    output logic [DATA_W-1:0] dev_wdata,
    output logic dev_wr,
    output logic dev_rd,
    input wire logic [DATA_W-1:0] dev_rdata,
    input wire logic dev_ack
);
    logic active_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            active_q <= 1'b0;
            dev_wr <= 1'b0;
            dev_rd <= 1'b0;
            dev_addr <= '0;
            dev_wdata <= '0;
            done <= 1'b0;
            rdata <= '0;
        end else begin
            done <= 1'b0;
            if (!active_q && go) begin
                active_q <= 1'b1;
                dev_addr <= addr;
                dev_wdata <= wdata;
                dev_wr <= !is_read;
                dev_rd <= is_read;
            end else if (active_q && dev_ack) begin
                // Strobe held until the channel answers
                active_q <= 1'b0;
                dev_wr <= 1'b0;
                dev_rd <= 1'b0;
                done <= 1'b1;
                rdata <= dev_rdata;
            end
        end
    end
endmodule

/* hdl/byte_counter.sv */
// Count of bytes still to be received
`timescale 1ns/100ps
module byte_counter #(
    parameter int LEN_W = rx_seq_pkg::LEN_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic [LEN_W-1:0] len,
    input wire logic dec,
    // State
    output logic [LEN_W-1:0] remaining,
    output logic is_last,
    output logic is_next_last
);
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            remaining <= '0;
        end else if (load) begin
            remaining <= len;
        end else if (dec && remaining != rx_seq_pkg::LEN_ZERO) begin
            remaining <= remaining - rx_seq_pkg::LEN_ONE;
        end
    end

    assign is_last = (remaining == rx_seq_pkg::LEN_ONE);
    assign is_next_last = (remaining == rx_seq_pkg::LEN_TWO);
endmodule

/* hdl/i2c_receive_sequencer.sv */
// Controller that runs master and slave receive sequences on the channel registers
`timescale 1ns/100ps
// Behaviour
// - Single-byte receive: request NACK before starting
// - After START, clear start-seen flag by 1
// - Load target address with READ bit one
// - On NACK clear flag, then request STOP
// - After NACK, retry with START or await STOP
// - Next-to-last byte in master: request NACK
// - Last master byte: read, then request STOP
// - Read every non-final byte, repeat until done
// - Clear stop-seen flag by writing 1
// - Slave: clear transfer-end flag by writing 1
// - Slave: request NACK before the final byte
// - After slave receive, repeated START rechecks direction
// - Slave STOP: clear flag, end sequence
module i2c_receive_sequencer #(
    parameter int ADDR_W = rx_seq_pkg::ADDR_W,
    parameter int DATA_W = rx_seq_pkg::DATA_W,
    parameter int LEN_W = rx_seq_pkg::LEN_W,
    parameter int RETRY_W = rx_seq_pkg::RETRY_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // User command
    input wire logic cmd_go,
    input wire logic cmd_slave,
    input wire logic [rx_seq_pkg::TARGET_W-1:0] cmd_target,
    input wire logic [LEN_W-1:0] cmd_len,
    input wire logic [RETRY_W-1:0] cmd_retries,
    // User status
    output logic busy,
    output logic [DATA_W-1:0] rx_data,
    output logic rx_valid,
    output logic done,
    output logic nack_fail,
    output logic slave_send,
    // Channel register port
    output logic [ADDR_W-1:0] dev_addr,
    output logic [DATA_W-1:0] dev_wdata,
    output logic dev_wr,
    output logic dev_rd,
    input wire logic [DATA_W-1:0] dev_rdata,
    input wire logic dev_ack
);
    typedef enum logic [4:0] {
        IDLE, NACK_CFG, START_REQ, POLL_START, CLR_START, LOAD_ADDR, POLL_RX, CLR_NACK, STOP_NACK,
        NACK_REQ, READ_RX, STOP_REQ, POLL_STOP, CLR_STOP, FINISH,
        SL_POLL_START, SL_SEND, SL_CLR_START, SL_POLL_RX, SL_CLR_END, SL_POLL_END
    } state_t;

    state_t state_q;
    logic slave_q;
    logic [rx_seq_pkg::TARGET_W-1:0] target_q;
    logic [LEN_W-1:0] len_q;
    logic [RETRY_W-1:0] retry_q;
    logic op_go_q;
    logic op_wait_q;
    logic op_done;
    logic [DATA_W-1:0] op_rdata;
    logic op_read;
    logic [ADDR_W-1:0] op_addr;
    logic [DATA_W-1:0] op_wdata;
    logic cnt_load;
    logic cnt_dec;
    logic is_last;
    logic is_next_last;
    logic nack_armed_q;

    function automatic logic [DATA_W-1:0] bit_word(input int pos);
        bit_word = '0;
        bit_word[pos] = 1'b1;
    endfunction

    function automatic logic flag_set(input logic [DATA_W-1:0] word, input int pos);
        flag_set = word[pos];
    endfunction

    // Register access implied by each state
    always_comb begin
        op_read = 1'b1;
        op_addr = rx_seq_pkg::CHANNEL_FLAG_REG;
        op_wdata = '0;
        case (state_q)
            NACK_CFG, NACK_REQ: begin
                op_read = 1'b0;
                op_addr = rx_seq_pkg::CHANNEL_CONTROL_REG;
                op_wdata = bit_word(rx_seq_pkg::NACK_REQUEST_BIT);
            end
            START_REQ: begin
                op_read = 1'b0;
                op_addr = rx_seq_pkg::CHANNEL_CONTROL_REG;
                op_wdata = bit_word(rx_seq_pkg::START_REQUEST_BIT);
            end
            STOP_NACK, STOP_REQ: begin
                op_read = 1'b0;
                op_addr = rx_seq_pkg::CHANNEL_CONTROL_REG;
                op_wdata = bit_word(rx_seq_pkg::STOP_REQUEST_BIT);
            end
            CLR_START, SL_CLR_START, SL_SEND: begin
                op_read = 1'b0;
                op_wdata = bit_word(rx_seq_pkg::START_SEEN_BIT);
            end
            CLR_NACK: begin
                op_read = 1'b0;
                op_wdata = bit_word(rx_seq_pkg::NACK_RECEIVED_BIT);
            end
            CLR_STOP: begin
                op_read = 1'b0;
                op_wdata = bit_word(rx_seq_pkg::STOP_SEEN_BIT);
            end
            SL_CLR_END: begin
                op_read = 1'b0;
                op_wdata = bit_word(rx_seq_pkg::TRANSFER_END_BIT);
            end
            LOAD_ADDR: begin
                op_read = 1'b0;
                op_addr = rx_seq_pkg::TRANSMIT_DATA_REG;
                op_wdata = {target_q, rx_seq_pkg::DIR_READ};
            end
            READ_RX: begin
                op_addr = rx_seq_pkg::RECEIVE_DATA_REG;
            end
            default: begin
                op_read = 1'b1;
            end
        endcase
    end

    // One register access at a time, reissued after each answer while the state is not IDLE or FINISH
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            op_go_q <= 1'b0;
            op_wait_q <= 1'b0;
        end else begin
            op_go_q <= 1'b0;
            if (op_done) begin
                op_wait_q <= 1'b0;
            end else if (!op_wait_q && state_q != IDLE && state_q != FINISH) begin
                op_go_q <= 1'b1;
                op_wait_q <= 1'b1;
            end
        end
    end

    assign cnt_load = (state_q == IDLE && cmd_go && cmd_len != rx_seq_pkg::LEN_ZERO)
        || (op_done && state_q == STOP_NACK)
        || (op_done && state_q == SL_POLL_END && flag_set(op_rdata, rx_seq_pkg::START_SEEN_BIT));
    assign cnt_dec = op_done && state_q == READ_RX;

    // Sequence control
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= IDLE;
            slave_q <= 1'b0;
            target_q <= '0;
            len_q <= '0;
            retry_q <= '0;
        end else begin
            case (state_q)
                IDLE: begin
                    if (cmd_go && cmd_len != rx_seq_pkg::LEN_ZERO) begin
                        slave_q <= cmd_slave;
                        target_q <= cmd_target;
                        len_q <= cmd_len;
                        retry_q <= cmd_retries;
                        if (cmd_len == rx_seq_pkg::LEN_ONE) begin
                            state_q <= NACK_CFG;
                        end else begin
                            state_q <= cmd_slave ? SL_POLL_START : START_REQ;
                        end
                    end
                end
                NACK_CFG: if (op_done) begin
                    state_q <= slave_q ? SL_POLL_START : START_REQ;
                end
                START_REQ: if (op_done) begin
                    state_q <= POLL_START;
                end
                POLL_START: if (op_done) begin
                    if (flag_set(op_rdata, rx_seq_pkg::START_SEEN_BIT)) begin
                        state_q <= CLR_START;
                    end else if (flag_set(op_rdata, rx_seq_pkg::TX_BUFFER_EMPTY_BIT)) begin
                        state_q <= LOAD_ADDR;
                    end
                end
                CLR_START: if (op_done) begin
                    state_q <= LOAD_ADDR;
                end
                LOAD_ADDR: if (op_done) begin
                    state_q <= POLL_RX;
                end
                POLL_RX: if (op_done) begin
                    if (flag_set(op_rdata, rx_seq_pkg::RX_BUFFER_FULL_BIT)) begin
                        state_q <= is_next_last ? NACK_REQ : READ_RX;
                    end else if (flag_set(op_rdata, rx_seq_pkg::NACK_RECEIVED_BIT)) begin
                        state_q <= CLR_NACK;
                    end
                end
                CLR_NACK: if (op_done) begin
                    state_q <= STOP_NACK;
                end
                STOP_NACK: if (op_done) begin
                    if (retry_q != rx_seq_pkg::RETRY_ZERO) begin
                        retry_q <= retry_q - rx_seq_pkg::RETRY_ONE;
                        state_q <= (len_q == rx_seq_pkg::LEN_ONE) ? NACK_CFG : START_REQ;
                    end else begin
                        state_q <= POLL_STOP;
                    end
                end
                NACK_REQ: if (op_done) begin
                    state_q <= READ_RX;
                end
                READ_RX: if (op_done) begin
                    if (is_last) begin
                        state_q <= slave_q ? SL_POLL_END : STOP_REQ;
                    end else begin
                        state_q <= slave_q ? SL_POLL_RX : POLL_RX;
                    end
                end
                STOP_REQ: if (op_done) begin
                    state_q <= POLL_STOP;
                end
                POLL_STOP: if (op_done && flag_set(op_rdata, rx_seq_pkg::STOP_SEEN_BIT)) begin
                    state_q <= CLR_STOP;
                end
                CLR_STOP: if (op_done) begin
                    state_q <= FINISH;
                end
                FINISH: begin
                    state_q <= IDLE;
                end
                SL_POLL_START: if (op_done && flag_set(op_rdata, rx_seq_pkg::START_SEEN_BIT)) begin
                    state_q <= flag_set(op_rdata, rx_seq_pkg::DIRECTION_BIT) ? SL_SEND : SL_CLR_START;
                end
                SL_SEND: if (op_done) begin
                    state_q <= FINISH;
                end
                SL_CLR_START: if (op_done) begin
                    state_q <= SL_POLL_RX;
                end
                SL_POLL_RX: if (op_done) begin
                    if (flag_set(op_rdata, rx_seq_pkg::RX_BUFFER_FULL_BIT)) begin
                        state_q <= is_next_last ? NACK_REQ : READ_RX;
                    end else if (flag_set(op_rdata, rx_seq_pkg::TRANSFER_END_BIT)) begin
                        state_q <= SL_CLR_END;
                    end
                end
                SL_CLR_END: if (op_done) begin
                    state_q <= SL_POLL_RX;
                end
                SL_POLL_END: if (op_done) begin
                    if (flag_set(op_rdata, rx_seq_pkg::STOP_SEEN_BIT)) begin
                        state_q <= CLR_STOP;
                    end else if (flag_set(op_rdata, rx_seq_pkg::START_SEEN_BIT)) begin
                        state_q <= SL_POLL_START;
                    end
                end
                default: begin
                    state_q <= IDLE;
                end
            endcase
        end
    end

    // User status outputs
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            rx_data <= '0;
            rx_valid <= 1'b0;
            done <= 1'b0;
            nack_fail <= 1'b0;
            slave_send <= 1'b0;
        end else begin
            rx_valid <= cnt_dec;
            if (cnt_dec) begin
                rx_data <= op_rdata;
            end
            done <= (state_q == FINISH);
            busy <= (state_q != FINISH) && (state_q != IDLE || (cmd_go && cmd_len != rx_seq_pkg::LEN_ZERO));
            if (state_q == IDLE && cmd_go) begin
                nack_fail <= 1'b0;
                slave_send <= 1'b0;
            end else if (op_done && state_q == STOP_NACK && retry_q == rx_seq_pkg::RETRY_ZERO) begin
                nack_fail <= 1'b1;
            end else if (op_done && state_q == SL_SEND) begin
                slave_send <= 1'b1;
            end
        end
    end

    // Whether the NACK_CFG request was written in this sequence
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            nack_armed_q <= 1'b0;
        end else if (state_q == IDLE) begin
            nack_armed_q <= 1'b0;
        end else if (op_done && state_q == NACK_CFG) begin
            nack_armed_q <= 1'b1;
        end
    end

    reg_access #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_access (
        .clk_sys(clk_sys),
        .reset(reset),
        .go(op_go_q),
        .is_read(op_read),
        .addr(op_addr),
        .wdata(op_wdata),
        .done(op_done),
        .rdata(op_rdata),
        .dev_addr(dev_addr),
        .dev_wdata(dev_wdata),
        .dev_wr(dev_wr),
        .dev_rd(dev_rd),
        .dev_rdata(dev_rdata),
        .dev_ack(dev_ack)
    );

    byte_counter #(.LEN_W(LEN_W)) u_count (
        .clk_sys(clk_sys),
        .reset(reset),
        .load(cnt_load),
        .len(cmd_go && state_q == IDLE ? cmd_len : len_q),
        .dec(cnt_dec),
        .remaining(),
        .is_last(is_last),
        .is_next_last(is_next_last)
    );

    property p_single_nack;
        @(posedge clk_sys) disable iff (reset)
        (state_q == START_REQ && op_go_q && len_q == rx_seq_pkg::LEN_ONE) |-> nack_armed_q;
    endproperty
    a_single_nack: assert property (p_single_nack) else $error("start without nack for one byte");

    property p_addr_read;
        @(posedge clk_sys) disable iff (reset)
        (dev_wr && dev_addr == rx_seq_pkg::TRANSMIT_DATA_REG) |-> (dev_wdata == {target_q, rx_seq_pkg::DIR_READ});
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("bad address byte");

    property p_start_clear;
        @(posedge clk_sys) disable iff (reset)
        (state_q == POLL_START && op_done && op_rdata[rx_seq_pkg::START_SEEN_BIT]) |=> state_q == CLR_START ##1
        (op_go_q && dev_wdata == '0) ##1 (dev_wr && dev_wdata == bit_word(rx_seq_pkg::START_SEEN_BIT));
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start flag not cleared");

    property p_nack_stop;
        @(posedge clk_sys) disable iff (reset)
        (state_q == CLR_NACK && op_done) |=> (state_q == STOP_NACK) ##2
        (dev_wr && dev_addr == rx_seq_pkg::CHANNEL_CONTROL_REG && dev_wdata[rx_seq_pkg::STOP_REQUEST_BIT]);
    endproperty
    a_nack_stop: assert property (p_nack_stop) else $error("no stop after nack");

    property p_retry;
        @(posedge clk_sys) disable iff (reset)
        (state_q == STOP_NACK && op_done) |=> (retry_q != $past(retry_q)) == (state_q != POLL_STOP);
    endproperty
    a_retry: assert property (p_retry) else $error("retry decision wrong");

    property p_next_last;
        @(posedge clk_sys) disable iff (reset)
        (op_done && (state_q == POLL_RX || state_q == SL_POLL_RX) && op_rdata[rx_seq_pkg::RX_BUFFER_FULL_BIT])
        |=> (state_q == NACK_REQ) == $past(is_next_last);
    endproperty
    a_next_last: assert property (p_next_last) else $error("nack request misplaced");

    property p_last_stop;
        @(posedge clk_sys) disable iff (reset)
        (state_q == READ_RX && op_done && is_last && !slave_q) |=> state_q == STOP_REQ ##0 rx_valid;
    endproperty
    a_last_stop: assert property (p_last_stop) else $error("last byte not followed by stop");

    property p_read_each;
        @(posedge clk_sys) disable iff (reset)
        (state_q == READ_RX && op_done) |=> rx_valid && rx_data == $past(op_rdata);
    endproperty
    a_read_each: assert property (p_read_each) else $error("received byte not delivered");

    property p_stop_clear;
        @(posedge clk_sys) disable iff (reset)
        (op_done && (state_q == POLL_STOP || state_q == SL_POLL_END) && op_rdata[rx_seq_pkg::STOP_SEEN_BIT])
        |=> state_q == CLR_STOP;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop flag not cleared");

    property p_end_clear;
        @(posedge clk_sys) disable iff (reset)
        (state_q == SL_POLL_RX && op_done && !op_rdata[rx_seq_pkg::RX_BUFFER_FULL_BIT]
        && op_rdata[rx_seq_pkg::TRANSFER_END_BIT]) |=> state_q == SL_CLR_END;
    endproperty
    a_end_clear: assert property (p_end_clear) else $error("transfer end flag not cleared");

    property p_restart_dir;
        @(posedge clk_sys) disable iff (reset)
        (state_q == SL_POLL_END && op_done && !op_rdata[rx_seq_pkg::STOP_SEEN_BIT]
        && op_rdata[rx_seq_pkg::START_SEEN_BIT]) |=> state_q == SL_POLL_START;
    endproperty
    a_restart_dir: assert property (p_restart_dir) else $error("direction not rechecked");
endmodule

/* verif/chan_model.sv */
// Behavioural channel: control, flag, transmit and receive registers
`timescale 1ns/100ps
module chan_model (
    // Clock, reset and register port
    input wire logic clk_sys, reset, dev_wr, dev_rd,
    input wire logic [1:0] dev_addr,
    input wire logic [7:0] dev_wdata,
    output logic [7:0] dev_rdata,
    output logic dev_ack,
    // Scenario control
    input wire logic kick, cmd_slave, dir, rep,
    input wire logic [3:0] nacks,
    input wire logic [7:0] cmd_len,
    input wire logic [1:0] lag,
    // Observation
    output logic [7:0] txb, bad, stops, flags
);
    localparam int TBE = rx_seq_pkg::TX_BUFFER_EMPTY_BIT, RBF = rx_seq_pkg::RX_BUFFER_FULL_BIT,
        SS = rx_seq_pkg::START_SEEN_BIT, SP = rx_seq_pkg::STOP_SEEN_BIT, NK = rx_seq_pkg::NACK_RECEIVED_BIT,
        TE = rx_seq_pkg::TRANSFER_END_BIT, DR = rx_seq_pkg::DIRECTION_BIT;
    logic [7:0] rd_q, idx_q;
    logic [3:0] nk_q;
    logic [1:0] cnt_q;
    logic ack_q, nreq_q, rep_q;
    assign dev_ack = ack_q;
    // Read bus shows the inverse outside the answer cycle
    assign dev_rdata = ack_q ? rd_q : ~rd_q;
    always_ff @(posedge clk_sys or posedge reset) begin
        logic [7:0] f, j;
        logic pres;
        if (reset) begin
            {flags, rd_q, idx_q, nk_q, cnt_q, ack_q, nreq_q, rep_q, txb, bad, stops} <= '0;
        end else begin
            f = flags;
            j = idx_q;
            pres = 1'b0;
            ack_q <= 1'b0;
            if (kick) begin
                nk_q <= nacks;
                j = 8'h00;
                rep_q <= rep;
                nreq_q <= 1'b0;
                f[SS] = cmd_slave | f[SS];
                f[DR] = cmd_slave & dir;
            end
            if ((dev_wr || dev_rd) && !ack_q) begin
                cnt_q <= cnt_q + 2'h1;
                if (cnt_q == lag) begin
                    cnt_q <= 2'h0;
                    ack_q <= 1'b1;
                    rd_q <= f;
                    if (dev_rd && dev_addr == rx_seq_pkg::RECEIVE_DATA_REG) begin
                        rd_q <= 8'ha0 + j;
                        f[RBF] = 1'b0;
                        j = j + 8'h01;
                        if (j < cmd_len) begin
                            f[TE] = cmd_slave;
                            pres = !cmd_slave;
                        end else if (cmd_slave && rep_q) begin
                            f[SS] = 1'b1;
                            f[DR] = 1'b1;
                            rep_q <= 1'b0;
                        end else begin
                            f[SP] = cmd_slave | f[SP];
                        end
                    end
                    if (dev_wr && dev_addr == rx_seq_pkg::CHANNEL_FLAG_REG) begin
                        pres = (cmd_slave && dev_wdata[SS] && f[SS] && !f[DR]) || (dev_wdata[TE] && f[TE]);
                        f = f & ~dev_wdata;
                    end
                    if (dev_wr && dev_addr == rx_seq_pkg::CHANNEL_CONTROL_REG) begin
                        if (dev_wdata[rx_seq_pkg::START_REQUEST_BIT]) begin
                            // Master with dir set answers START with buffer empty only
                            f[SS] = !dir | cmd_slave;
                            f[TBE] = 1'b1;
                        end
                        if (dev_wdata[rx_seq_pkg::NACK_REQUEST_BIT]) begin
                            nreq_q <= 1'b1;
                        end
                        if (dev_wdata[rx_seq_pkg::STOP_REQUEST_BIT]) begin
                            f[SP] = 1'b1;
                            nreq_q <= 1'b0;
                            stops <= stops + 8'h01;
                            bad <= bad + {7'h00, f[RBF]};
                        end
                    end
                    if (dev_wr && dev_addr == rx_seq_pkg::TRANSMIT_DATA_REG) begin
                        txb <= dev_wdata;
                        f[TBE] = 1'b0;
                        pres = (nk_q == 4'h0);
                        f[NK] = !pres;
                        nk_q <= nk_q - {3'h0, !pres};
                    end
                end
            end
            if (pres) begin
                f[RBF] = 1'b1;
                bad <= bad + {7'h00, nreq_q != (j == cmd_len - 8'h01)};
            end
            flags <= f;
            idx_q <= j;
        end
    end
endmodule

/* verif/tb_i2c_receive_sequencer.sv */
// Self-checking bench of the receive sequencer against the channel model
`timescale 1ns/100ps
module tb_i2c_receive_sequencer;
    logic clk_sys = 1'b0, reset = 1'b1, cmd_go = 1'b0, cmd_slave = 1'b0, kick = 1'b0, dir = 1'b0, rep = 1'b0;
    logic [rx_seq_pkg::TARGET_W-1:0] cmd_target = 7'h00;
    logic [7:0] cmd_len = 8'h00;
    logic [3:0] cmd_retries = 4'h0, nacks = 4'h0;
    logic [1:0] lag = 2'h0, dev_addr;
    logic busy, rx_valid, done, nack_fail, slave_send, dev_wr, dev_rd, dev_ack;
    logic [7:0] rx_data, dev_wdata, dev_rdata, txb, bad, stops, flags;
    int num_errors = 0, n_tests = 0;
    i2c_receive_sequencer i_i2c_receive_sequencer (.clk_sys(clk_sys), .reset(reset), .cmd_go(cmd_go),
        .cmd_slave(cmd_slave), .cmd_target(cmd_target), .cmd_len(cmd_len), .cmd_retries(cmd_retries),
        .busy(busy), .rx_data(rx_data), .rx_valid(rx_valid), .done(done), .nack_fail(nack_fail),
        .slave_send(slave_send), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
        .dev_rd(dev_rd), .dev_rdata(dev_rdata), .dev_ack(dev_ack));
    chan_model i_chan_model (.clk_sys(clk_sys), .reset(reset), .dev_wr(dev_wr), .dev_rd(dev_rd),
        .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack), .kick(kick),
        .cmd_slave(cmd_slave), .dir(dir), .rep(rep), .nacks(nacks), .cmd_len(cmd_len), .lag(lag),
        .txb(txb), .bad(bad), .stops(stops), .flags(flags));
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic run(input logic s, d, r, input logic [3:0] nk, rt, input logic [7:0] len, input logic [1:0] lg);
        logic [7:0] k, st0;
        logic fail;
        int t;
        k = 8'h00;
        st0 = stops;
        fail = !s && nk > rt;
        @(posedge clk_sys);
        #1;
        {cmd_slave, dir, rep, nacks, cmd_retries, cmd_len, lag} = {s, d, r, nk, rt, len, lg};
        cmd_target = 7'h2c + len[6:0];
        cmd_go = 1'b1;
        kick = 1'b1;
        @(posedge clk_sys);
        #1;
        cmd_go = 1'b0;
        kick = 1'b0;
        check("busy", {7'h00, busy}, 8'h01);
        for (t = 0; t < 4000 && done !== 1'b1; t++) begin
            @(posedge clk_sys);
            #1;
            if (rx_valid === 1'b1) begin
                check("rx_data", rx_data, 8'ha0 + k);
                k++;
            end
        end
        check("done", {7'h00, done}, 8'h01);
        check("bytes", k, (fail || (s && d)) ? 8'h00 : len);
        check("nack_fail", {7'h00, nack_fail}, {7'h00, fail});
        check("slave_send", {7'h00, slave_send}, {7'h00, s && (d || r)});
        check("ack_nack", bad, 8'h00);
        check("flags", flags & 8'h3e, 8'h00);
        check("stops", stops - st0, s ? 8'h00 : {4'h0, fail ? rt : nk} + 8'h01);
        if (!s)
            check("address", txb, {cmd_target, rx_seq_pkg::DIR_READ});
    endtask
    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        run(0, 0, 0, 4'h0, 4'h0, 8'h01, 2'h0);
        run(0, 0, 0, 4'h0, 4'h0, 8'h02, 2'h3);
        run(0, 1, 0, 4'h0, 4'h0, 8'h05, 2'h1);
        run(0, 0, 0, 4'h2, 4'h2, 8'h03, 2'h0);
        run(0, 0, 0, 4'h3, 4'h1, 8'h02, 2'h2);
        run(0, 0, 0, 4'h1, 4'h1, 8'h01, 2'h1);
        run(1, 0, 0, 4'h0, 4'h0, 8'h01, 2'h0);
        run(1, 0, 0, 4'h0, 4'h0, 8'h04, 2'h2);
        run(1, 0, 1, 4'h0, 4'h0, 8'h02, 2'h1);
        run(1, 1, 0, 4'h0, 4'h0, 8'h03, 2'h0);
        cmd_len = 8'h00;
        cmd_go = 1'b1;
        @(posedge clk_sys);
        #1;
        cmd_go = 1'b0;
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            check("idle", {6'h00, busy, done}, 8'h00);
        end
        give_verdict();
    end
endmodule
